/* File: sar_flag_latch.sv */
// Sticky latch of the status flags that feed the latched alert mode
`timescale 1ns/1ps
`default_nettype none

module sar_flag_latch #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Live flags and host clear
  input  wire logic [W-1:0] set_in,
  input  wire logic         clear_in,
  // Latched flags
  output logic      [W-1:0] latched_out
);

  // A flag raised in the clearing cycle survives, so no event is lost
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      latched_out <= '0;
    end else begin
      latched_out <= (latched_out & ~{W{clear_in}}) | set_in;
    end
  end

endmodule
`default_nettype wire

/* File: sar_host_model.sv */
// Bus engine model that issues whole-word accesses to the routing register
`timescale 1ns/1ps
`default_nettype none

module sar_host_model (
  // Clock
  input  wire logic        sys_clk_in,
  // Register port
  output logic      [7:0]  cmd_code_out,
  output logic             wr_word_out,
  output logic      [15:0] wr_data_out,
  output logic             rd_word_out
);
  // ************************************************************
  // Bus cycles
  // ************************************************************
  // Idle bus at time zero
  initial begin
    cmd_code_out = 8'h00;
    wr_word_out  = 1'b0;
    wr_data_out  = 16'h0000;
    rd_word_out  = 1'b0;
  end

  // One whole word per write; code and data inverted once released
  task automatic write_word(input logic [7:0] code, input logic [15:0] data);
    @(posedge sys_clk_in);
    cmd_code_out <= code;
    wr_data_out  <= data;
    wr_word_out  <= 1'b1;
    @(posedge sys_clk_in);
    wr_word_out  <= 1'b0;
    cmd_code_out <= ~code; // Stale code would hide decode slips
    wr_data_out  <= ~data;
  endtask

  // One-cycle read strobe; answer shows right after the taking edge
  task automatic read_word(input logic [7:0] code);
    @(posedge sys_clk_in);
    cmd_code_out <= code;
    rd_word_out  <= 1'b1;
    @(posedge sys_clk_in);
    rd_word_out  <= 1'b0;
    cmd_code_out <= ~code;
  endtask
endmodule

`default_nettype wire

/* File: sar_pin_drive.sv */
// Mode selection and registered drive of the second output pin
`timescale 1ns/1ps
`default_nettype none

module sar_pin_drive (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // Configuration
  input  wire sar_pkg::sar_mode_e mode_in,
  input  wire logic              polarity_in,
  // Conditions
  input  wire logic              alert_in,
  input  wire logic              cmp_in,
  input  wire logic              retry_fail_in,
  // Pin
  output logic                   pin_out
);

  logic next_pin;

  // Alert, retry and comparator are active low; GPO drives the polarity bit
  always_comb begin
    unique case (mode_in)
      sar_pkg::MODE_ALERT: next_pin = ~alert_in;
      sar_pkg::MODE_GPO:   next_pin = polarity_in;
      sar_pkg::MODE_RETRY: next_pin = ~retry_fail_in;
      sar_pkg::MODE_CMP:   next_pin = ~cmp_in;
    endcase
  end

  // Registered so the pin never glitches on mixed flag edges
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_out <= 1'b1;
    end else begin
      pin_out <= next_pin;
    end
  end

endmodule
`default_nettype wire

/* File: sar_pkg.sv */
// Register map, field positions and output mode codes for the second alert output block
package sar_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0]  CFG_CMD   = 8'hd6;   // Command code of the routing register
  localparam logic [15:0] CFG_RESET = 16'h0004; // Enables clear, retry-fail mode, active low
  localparam int          CFG_W     = 16;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FET_BIT     = 15;
  localparam int OC_FLT_BIT  = 14;
  localparam int VOV_FLT_BIT = 13;
  localparam int VUV_FLT_BIT = 12;
  localparam int CML_BIT     = 11;
  localparam int OC_WRN_BIT  = 10;
  localparam int IW2_BIT     = 9;
  localparam int VOV_WRN_BIT = 8;
  localparam int VUV_WRN_BIT = 7;
  localparam int AOV_WRN_BIT = 6;
  localparam int AUV_WRN_BIT = 5;
  localparam int ILIM_BIT    = 4;
  localparam int OP_WRN_BIT  = 3;
  localparam int MODE_MSB    = 2;
  localparam int MODE_LSB    = 1;
  localparam int POL_BIT     = 0;

  // Enable bits 15..3 map onto flag vector bits 12..0
  localparam int FLAG_BASE = 3;
  localparam int NUM_FLAGS = 13;

  // ************************************************************
  // Output mode codes
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_ALERT = 2'h0,
    MODE_GPO   = 2'h1,
    MODE_RETRY = 2'h2,
    MODE_CMP   = 2'h3
  } sar_mode_e;

endpackage

/* File: sar_top.sv */
// Routing register and drive logic of the second alert / general-purpose output
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Routing register resets to 0x0004: enables clear, mode retry-fail.
// - Bit 15 routes the pass transistor health flag to the output.
// - Bit 14 routes the output overcurrent fault flag; host clear resets it like the others.
// - Bit 13 routes the input overvoltage fault flag; host clear resets it like the others.
// - Bit 12 routes the input undervoltage fault flag; host clear resets it like the others.
// - Bit 11 routes the communication, memory or logic error flag.
// - Bit 10 routes the output overcurrent warning flag.
// - Bit 9 routes the second output current warning flag.
// - Bit 8 routes the input overvoltage warning flag.
// - Bit 7 routes the input undervoltage warning flag.
// - Bit 6 routes the auxiliary input overvoltage warning flag.
// - Bit 5 routes the auxiliary input undervoltage warning flag.
// - Bit 4 routes the hot swap current limit fault flag.
// - Bit 3 routes the input overpower warning flag.
// - Mode 00 makes the pin a latched alert from enabled flags.
// - Mode 01 makes the pin a plain output set by the polarity bit.
// - Mode 10, the reset mode, shows the retry-fail condition.
// - Mode 11 follows live enabled flags unlatched, a digital comparator.
// - Polarity bit sets the pin level in mode 01 only; modes 00, 10 and 11 are always active low.
module sar_top (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Register port from the bus engine
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic        wr_word_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        rd_word_in,
  output logic      [15:0] rd_data_out,
  output logic             rd_hit_out,
  // Live status flags
  input  wire logic        pass_transistor_health_bad_flag_in,
  input  wire logic        output_overcurrent_fault_flag_in,
  input  wire logic        input_overvoltage_fault_flag_in,
  input  wire logic        input_undervoltage_fault_flag_in,
  input  wire logic        comm_memory_logic_error_flag_in,
  input  wire logic        output_overcurrent_warning_flag_in,
  input  wire logic        second_current_warning_flag_in,
  input  wire logic        input_overvoltage_warning_flag_in,
  input  wire logic        input_undervoltage_warning_flag_in,
  input  wire logic        aux_overvoltage_warning_flag_in,
  input  wire logic        aux_undervoltage_warning_flag_in,
  input  wire logic        hot_swap_current_limit_fault_flag_in,
  input  wire logic        input_overpower_warning_flag_in,
  // Host clear of latched flags
  input  wire logic        clear_flags_in,
  // Retry logic
  input  wire logic        retry_fail_in,
  // Output pin
  output logic             second_output_pin_out
);

  // ************************************************************
  // Register decode
  // ************************************************************

  // Shared by the write and read paths
  function automatic logic cmd_hit(input logic [7:0] code);
    return code == sar_pkg::CFG_CMD;
  endfunction

  logic [15:0]                     cfg;
  logic                            wr_hit;
  logic                            rd_hit;
  logic [sar_pkg::NUM_FLAGS-1:0]   live;
  logic [sar_pkg::NUM_FLAGS-1:0]   enables;
  logic [sar_pkg::NUM_FLAGS-1:0]   latched;
  logic                            alert_any;
  logic                            cmp_any;
  sar_pkg::sar_mode_e              second_output_mode_select;
  logic                            second_output_polarity;

  assign wr_hit = wr_word_in & cmd_hit(cmd_code_in);
  assign rd_hit = rd_word_in & cmd_hit(cmd_code_in);

  // ************************************************************
  // Routing register
  // ************************************************************

  // Whole-word write only; the bus engine assembles both bytes first
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg <= sar_pkg::CFG_RESET;
    end else if (wr_hit) begin
      cfg <= wr_data_in;
    end
  end

  // Readback of the stored word, one cycle after the request
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
      rd_hit_out  <= 1'b0;
    end else begin
      rd_hit_out  <= rd_hit;
      rd_data_out <= rd_hit ? cfg : '0;
    end
  end

  // ************************************************************
  // Field views
  // ************************************************************

  // Enable bits; bit 15 resets clear, so the health alert needs software
  logic fet_health_alert_enable;
  logic overcurrent_fault_alert_enable;
  logic input_overvoltage_fault_alert_enable;
  logic input_undervoltage_fault_alert_enable;
  logic comm_logic_error_alert_enable;
  logic overcurrent_warning_alert_enable;
  logic second_current_warning_alert_enable;
  logic input_overvoltage_warning_alert_enable;
  logic input_undervoltage_warning_alert_enable;
  logic aux_overvoltage_warning_alert_enable;
  logic aux_undervoltage_warning_alert_enable;
  logic current_limit_fault_alert_enable;
  logic overpower_warning_alert_enable;

  assign fet_health_alert_enable                = cfg[sar_pkg::FET_BIT];
  assign overcurrent_fault_alert_enable         = cfg[sar_pkg::OC_FLT_BIT];
  assign input_overvoltage_fault_alert_enable   = cfg[sar_pkg::VOV_FLT_BIT];
  assign input_undervoltage_fault_alert_enable  = cfg[sar_pkg::VUV_FLT_BIT];
  assign comm_logic_error_alert_enable          = cfg[sar_pkg::CML_BIT];
  assign overcurrent_warning_alert_enable       = cfg[sar_pkg::OC_WRN_BIT];
  assign second_current_warning_alert_enable    = cfg[sar_pkg::IW2_BIT];
  assign input_overvoltage_warning_alert_enable = cfg[sar_pkg::VOV_WRN_BIT];
  assign input_undervoltage_warning_alert_enable = cfg[sar_pkg::VUV_WRN_BIT];
  assign aux_overvoltage_warning_alert_enable   = cfg[sar_pkg::AOV_WRN_BIT];
  assign aux_undervoltage_warning_alert_enable  = cfg[sar_pkg::AUV_WRN_BIT];
  assign current_limit_fault_alert_enable       = cfg[sar_pkg::ILIM_BIT];
  assign overpower_warning_alert_enable         = cfg[sar_pkg::OP_WRN_BIT];

  assign enables = cfg[sar_pkg::FET_BIT:sar_pkg::FLAG_BASE];

  // Mode and polarity fields
  assign second_output_mode_select =
    sar_pkg::sar_mode_e'(cfg[sar_pkg::MODE_MSB:sar_pkg::MODE_LSB]);
  assign second_output_polarity = cfg[sar_pkg::POL_BIT];

  // Flags packed in the same order as their enable bits
  assign live = {pass_transistor_health_bad_flag_in,
                 output_overcurrent_fault_flag_in,
                 input_overvoltage_fault_flag_in,
                 input_undervoltage_fault_flag_in,
                 comm_memory_logic_error_flag_in,
                 output_overcurrent_warning_flag_in,
                 second_current_warning_flag_in,
                 input_overvoltage_warning_flag_in,
                 input_undervoltage_warning_flag_in,
                 aux_overvoltage_warning_flag_in,
                 aux_undervoltage_warning_flag_in,
                 hot_swap_current_limit_fault_flag_in,
                 input_overpower_warning_flag_in};

  // ************************************************************
  // Alert sources
  // ************************************************************

  // Flags latch regardless of enables, so enabling later still reports
  sar_flag_latch #(
    .W (sar_pkg::NUM_FLAGS)
  ) u_latch (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .set_in      (live),
    .clear_in    (clear_flags_in),
    .latched_out (latched)
  );

  // Enable gating for latched and live paths
  assign alert_any = |(latched & enables);
  assign cmp_any   = |(live & enables);

  // ************************************************************
  // Pin drive
  // ************************************************************

  // Mode select and output flop
  sar_pin_drive u_drive (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .mode_in       (second_output_mode_select),
    .polarity_in   (second_output_polarity),
    .alert_in      (alert_any),
    .cmp_in        (cmp_any),
    .retry_fail_in (retry_fail_in),
    .pin_out       (second_output_pin_out)
  );

  // ************************************************************
  // Checks
  // ************************************************************

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  logic m_cmp;
  logic m_alert;
  assign m_cmp   = second_output_mode_select == sar_pkg::MODE_CMP;
  assign m_alert = second_output_mode_select == sar_pkg::MODE_ALERT;

  a_reset_value:
    assert property ($fell(rst_in) |-> cfg == sar_pkg::CFG_RESET)
    else $error("config not at reset value");

  a_fet_route:
    assert property ((m_cmp && fet_health_alert_enable && pass_transistor_health_bad_flag_in)
                     |=> !second_output_pin_out)
    else $error("health flag not routed");

  a_ocf_route:
    assert property ((m_cmp && overcurrent_fault_alert_enable && output_overcurrent_fault_flag_in)
                     |=> !second_output_pin_out)
    else $error("overcurrent fault not routed");

  a_vovf_route:
    assert property ((m_cmp && input_overvoltage_fault_alert_enable && input_overvoltage_fault_flag_in)
                     |=> !second_output_pin_out)
    else $error("input ov fault not routed");

  a_vuvf_route:
    assert property ((m_cmp && input_undervoltage_fault_alert_enable && input_undervoltage_fault_flag_in)
                     |=> !second_output_pin_out)
    else $error("input uv fault not routed");

  a_cml_route:
    assert property ((m_cmp && comm_logic_error_alert_enable && comm_memory_logic_error_flag_in)
                     |=> !second_output_pin_out)
    else $error("logic error not routed");

  a_ocw_route:
    assert property ((m_cmp && overcurrent_warning_alert_enable && output_overcurrent_warning_flag_in)
                     |=> !second_output_pin_out)
    else $error("overcurrent warning not routed");

  a_iw2_route:
    assert property ((m_cmp && second_current_warning_alert_enable && second_current_warning_flag_in)
                     |=> !second_output_pin_out)
    else $error("second current warning not routed");

  a_vovw_route:
    assert property ((m_cmp && input_overvoltage_warning_alert_enable && input_overvoltage_warning_flag_in)
                     |=> !second_output_pin_out)
    else $error("input ov warning not routed");

  a_vuvw_route:
    assert property ((m_cmp && input_undervoltage_warning_alert_enable && input_undervoltage_warning_flag_in)
                     |=> !second_output_pin_out)
    else $error("input uv warning not routed");

  a_aovw_route:
    assert property ((m_cmp && aux_overvoltage_warning_alert_enable && aux_overvoltage_warning_flag_in)
                     |=> !second_output_pin_out)
    else $error("aux ov warning not routed");

  a_auvw_route:
    assert property ((m_cmp && aux_undervoltage_warning_alert_enable && aux_undervoltage_warning_flag_in)
                     |=> !second_output_pin_out)
    else $error("aux uv warning not routed");

  a_ilim_route:
    assert property ((m_cmp && current_limit_fault_alert_enable && hot_swap_current_limit_fault_flag_in)
                     |=> !second_output_pin_out)
    else $error("current limit fault not routed");

  a_opw_route:
    assert property ((m_cmp && overpower_warning_alert_enable && input_overpower_warning_flag_in)
                     |=> !second_output_pin_out)
    else $error("overpower warning not routed");

  a_cmp_quiet:
    assert property ((m_cmp && (live & enables) == '0) |=> second_output_pin_out)
    else $error("comparator asserted without enabled flag");

  a_alert_latch:
    assert property ((m_alert && |(live & enables) && !clear_flags_in)
                     ##1 (m_alert && !clear_flags_in && $stable(cfg)) [*2]
                     |=> !second_output_pin_out)
    else $error("alert did not latch");

  a_alert_release:
    assert property ((m_alert && (latched & enables) == '0) |=> second_output_pin_out)
    else $error("alert held with nothing latched");

  a_gpo_level:
    assert property ((second_output_mode_select == sar_pkg::MODE_GPO)
                     |=> second_output_pin_out == $past(second_output_polarity))
    else $error("gpo level not polarity bit");

  a_retry_show:
    assert property ((!rst_in && second_output_mode_select == sar_pkg::MODE_RETRY)
                     |=> second_output_pin_out == !$past(retry_fail_in))
    else $error("retry fail not shown");

  a_word_readback:
    assert property ((wr_hit ##1 !wr_word_in ##1 (rd_hit && !wr_word_in))
                     |=> rd_hit_out && rd_data_out == $past(wr_data_in, 3))
    else $error("readback differs from write");

  a_miss_ignored:
    assert property ((wr_word_in && !cmd_hit(cmd_code_in)) |=> $stable(cfg))
    else $error("foreign command changed config");

  // Reset levels; explicit disable so the reset cycles themselves are watched
  a_reset_outputs:
    assert property (disable iff (1'b0) rst_in |=> second_output_pin_out && !rd_hit_out && rd_data_out == '0)
    else $error("outputs not at reset level");

  a_hit_pulse:
    assert property ((!rst_in && rd_hit) |=> rd_hit_out)
    else $error("read hit not flagged");

  a_miss_quiet:
    assert property (!rd_hit |=> !rd_hit_out && rd_data_out == '0)
    else $error("read data without hit");

  a_write_lands:
    assert property ((!rst_in && wr_hit) |=> cfg == $past(wr_data_in))
    else $error("write did not land");

  // Set wins over clear, so a flag raised in the clearing cycle is kept
  a_latch_set:
    assert property (!rst_in |=> (latched & $past(live)) == $past(live))
    else $error("live flag not latched");

  a_latch_hold:
    assert property (!clear_flags_in |=> (latched & $past(latched)) == $past(latched))
    else $error("latched flag lost without clear");

  a_latch_clear:
    assert property ((clear_flags_in && live == '0) |=> latched == '0)
    else $error("clear left flags latched");

  a_alert_active:
    assert property ((m_alert && (latched & enables) != '0) |=> !second_output_pin_out)
    else $error("latched enabled flag not shown");

  a_cmp_masked:
    assert property ((m_cmp && live != '0 && (live & enables) == '0) |=> second_output_pin_out)
    else $error("disabled flag reached the pin");

endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the second alert routing block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  cmd;
  logic        wr;
  logic [15:0] wdata;
  logic        rd;
  logic [15:0] rd_data;
  logic        rd_hit;
  logic [12:0] flags = 13'h0000;
  logic        clear = 1'b0;
  logic        retry = 1'b0;
  logic        pin;
  logic [15:0] ref_cfg;
  logic [12:0] ref_latch;
  logic        ref_pin;
  logic        ref_hit;
  logic [15:0] ref_rd;
  logic        chk_on = 1'b0;
  int          n_fail = 0;
  int          n_tests = 0;
  localparam logic [7:0] CMD = sar_pkg::CFG_CMD;

  // 10 MHz clock
  always #50 sys_clk_in = ~sys_clk_in;

  sar_host_model host_u (
    .sys_clk_in  (sys_clk_in),
    .cmd_code_out(cmd),
    .wr_word_out (wr),
    .wr_data_out (wdata),
    .rd_word_out (rd)
  );

  sar_top dut_u (
    .sys_clk_in                          (sys_clk_in),
    .rst_in                              (rst_in),
    .cmd_code_in                         (cmd),
    .wr_word_in                          (wr),
    .wr_data_in                          (wdata),
    .rd_word_in                          (rd),
    .rd_data_out                         (rd_data),
    .rd_hit_out                          (rd_hit),
    .pass_transistor_health_bad_flag_in  (flags[12]),
    .output_overcurrent_fault_flag_in    (flags[11]),
    .input_overvoltage_fault_flag_in     (flags[10]),
    .input_undervoltage_fault_flag_in    (flags[9]),
    .comm_memory_logic_error_flag_in     (flags[8]),
    .output_overcurrent_warning_flag_in  (flags[7]),
    .second_current_warning_flag_in      (flags[6]),
    .input_overvoltage_warning_flag_in   (flags[5]),
    .input_undervoltage_warning_flag_in  (flags[4]),
    .aux_overvoltage_warning_flag_in     (flags[3]),
    .aux_undervoltage_warning_flag_in    (flags[2]),
    .hot_swap_current_limit_fault_flag_in(flags[1]),
    .input_overpower_warning_flag_in     (flags[0]),
    .clear_flags_in                      (clear),
    .retry_fail_in                       (retry),
    .second_output_pin_out               (pin)
  );

  // ************************************************************
  // Reference model
  // ************************************************************
  // Pin level wanted from the register, latched and live flags
  function automatic logic exp_pin(logic [15:0] c, logic [12:0] l, logic [12:0] f, logic r);
    logic [12:0] en;
    en = c[15:sar_pkg::FLAG_BASE];
    case (c[sar_pkg::MODE_MSB:sar_pkg::MODE_LSB])
      sar_pkg::MODE_ALERT: return !(|(l & en));
      sar_pkg::MODE_GPO:   return c[sar_pkg::POL_BIT];
      sar_pkg::MODE_RETRY: return !r;
      default:             return !(|(f & en));
    endcase
  endfunction

  // Same edge as the design, so both see the same old inputs
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      ref_cfg   <= sar_pkg::CFG_RESET;
      ref_latch <= 13'h0000;
      ref_pin   <= 1'b1;
      ref_hit   <= 1'b0;
      ref_rd    <= 16'h0000;
    end else begin
      ref_pin   <= exp_pin(ref_cfg, ref_latch, flags, retry);
      ref_hit   <= rd && (cmd == CMD);
      ref_rd    <= (rd && (cmd == CMD)) ? ref_cfg : 16'h0000;
      ref_latch <= (clear ? 13'h0000 : ref_latch) | flags; // Set wins over clear
      if (wr && (cmd == CMD)) begin
        ref_cfg <= wdata;
      end
    end
  end

  // ************************************************************
  // Checking and verdict
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // Outputs compared every cycle at the settled falling edge
  always @(negedge sys_clk_in) begin
    if (chk_on) begin
      check({15'h0000, pin}, {15'h0000, ref_pin}, "pin level");
      check({15'h0000, rd_hit}, {15'h0000, ref_hit}, "read hit");
      check(rd_data, ref_rd, "read data");
    end
  end

  // Hang guard, far beyond the one to two thousand cycles of the tests
  initial begin
    #(100 * 40000);
    n_fail++;
    print_verdict();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    logic [15:0] d;
    void'($urandom(5));
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    chk_on <= 1'b1;
    // Reset word, then unmapped code ignored
    host_u.read_word(CMD);
    wait_n(1);
    check(rd_data, 16'h0004, "reset word");
    host_u.write_word(8'hd7, 16'hffff);
    host_u.read_word(8'hd7);
    wait_n(1);
    check({15'h0000, rd_hit}, 16'h0000, "unmapped hit");
    // Retry-fail mode shown from reset
    @(posedge sys_clk_in) retry <= 1'b1;
    wait_n(2);
    check({15'h0000, pin}, 16'h0000, "retry asserted");
    // Whole-word writes read back, back to back
    repeat (12) begin
      d = 16'($urandom);
      host_u.write_word(CMD, d);
      host_u.read_word(CMD);
      wait_n(1);
      check(rd_data, d, "readback");
    end
    // Each enable alone in comparator mode: own flag asserts, others do not
    for (int i = 3; i < 16; i++) begin
      host_u.write_word(CMD, 16'(1 << i) | 16'h0006);
      @(posedge sys_clk_in) flags <= 13'(1 << (i - 3));
      wait_n(2);
      check({15'h0000, pin}, 16'h0000, "enabled flag");
      @(posedge sys_clk_in) flags <= ~13'(1 << (i - 3));
      wait_n(2);
      check({15'h0000, pin}, 16'h0001, "disabled flags");
    end
    // Latched alert holds after the flag drops until a clear
    @(posedge sys_clk_in) flags <= 13'h0000;
    clear <= 1'b1;
    @(posedge sys_clk_in) clear <= 1'b0;
    host_u.write_word(CMD, 16'h4000);
    @(posedge sys_clk_in) flags <= 13'h0800;
    @(posedge sys_clk_in) flags <= 13'h0000;
    wait_n(3);
    check({15'h0000, pin}, 16'h0000, "alert held");
    @(posedge sys_clk_in) clear <= 1'b1;
    @(posedge sys_clk_in) clear <= 1'b0;
    wait_n(2);
    check({15'h0000, pin}, 16'h0001, "alert released");
    // General-purpose output, both polarities
    for (int p = 0; p < 2; p++) begin
      host_u.write_word(CMD, 16'h0002 | 16'(p));
      wait_n(2);
      check({15'h0000, pin}, 16'(p), "gpo level");
    end
    // Random traffic, reference model judges every cycle
    repeat (800) begin
      @(posedge sys_clk_in);
      flags <= 13'($urandom) & 13'($urandom) & 13'($urandom);
      clear <= ($urandom % 16) == 0;
      retry <= 1'($urandom);
      if ($urandom % 12 == 0) host_u.write_word(($urandom % 4 == 0) ? 8'hd5 : CMD, 16'($urandom));
      if ($urandom % 10 == 0) host_u.read_word(CMD);
    end
    // Second reset in mid-run restores the reset word
    @(posedge sys_clk_in) rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    host_u.read_word(CMD);
    wait_n(1);
    check(rd_data, 16'h0004, "word after reset");
    wait_n(2);
    print_verdict();
  end
endmodule

`default_nettype wire
